// *** mmw_decoder.sv ***
// Memory-map decoder and wait-state generator (device end)
// What this block does
// - Largest variant: eight 32K sectors from 0x300000
// - Middle variant: eight 16K sectors from 0x320000
// - Smallest variant: four 16K sectors from 0x330000
// - Top sector ends 0x33FF7F; security fill above
// - Decode boot-to-flash entry words 0x33FFF6-7
// - Password words never programmed all zero
// - Secured: fill region holds zeros only
// - Unsecured: 0x33FFF0-F5 data only, no code
// - Frames 1-3 form one protected group
// - Unprotected read may pass pending write
// - Protected write-then-read kept in order, stalled
// - Frame 0: CPU 0/1 waits, DMA reads only
// - Frame 3: CPU 0/2, DMA 0/1 waits
// - Frame 1: CPU 0/2 waits, no DMA
// - Frame 1 access stretched while ready low
// - Back-to-back frame 1 writes stall once
// - Frame 2: fixed CPU 0/2, no DMA
// - Peripheral frames refused in program space
`timescale 1ns/1ps
module mmw_decoder
    import mmw_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // Master bus
    mmw_bus_if.device              bus,
    // Configuration
    input  wire mmw_variant_t      variant,
    input  wire logic              protectEnable,
    // Peripheral ready pin of frame 1
    input  wire logic              periphReadyPin,
    // Decode result of the last access taken
    output mmw_region_t            region,
    output logic [2:0]             sectorIdx,
    // Memory bus
    output logic                   memStrobe,
    output logic                   memWrite,
    output logic [ADDR_W-1:0]      memAddr,
    output logic [DATA_W-1:0]      memData
);
    typedef enum logic {ST_IDLE, ST_WAIT} mmw_dec_state_t;

    function automatic mmw_region_t decodeRegion(input logic [21:0] a, input mmw_variant_t v);
        logic [21:0] flashLo;
        flashLo = (v == VAR_LARGE) ? FLASH_LARGE_LO : (v == VAR_MIDDLE) ? FLASH_MIDDLE_LO : FLASH_SMALL_LO;
        if (a <= RAM_A_HI) return REG_RAM_A;
        if (a >= RAM_B_LO && a <= RAM_B_HI) return REG_RAM_B;
        if (a >= PF0_LO && a <= PF0_HI) return REG_PF0;
        if (a >= PF1_LO && a <= PF1_HI) return REG_PF1;
        if (a >= PF2_LO && a <= PF2_HI) return REG_PF2;
        if (a >= PF3_LO && a <= PF3_HI) return REG_PF3;
        if (a >= flashLo && a <= FLASH_TOP) return REG_FLASH;
        if (a >= SEC_FILL_LO && a <= SEC_FILL_HI) return REG_SEC_FILL;
        if (a >= BOOT_ENTRY_LO && a <= BOOT_ENTRY_HI) return REG_BOOT_ENTRY;
        if (a >= PASSWORD_LO) return REG_PASSWORD;
        return REG_NONE;
    endfunction : decodeRegion

    // Sector letter code: 0 is A, counting up toward H at lower addresses
    function automatic logic [2:0] sectorOf(input logic [21:0] a, input mmw_variant_t v);
        logic [21:0] off;
        off = 22'h00_0000;
        unique case (v)
            VAR_LARGE: begin
                off = a - FLASH_LARGE_LO;
                return TOP_SECTOR_EIGHT - off[LARGE_SECTOR_SHIFT+:3];
            end
            VAR_MIDDLE: begin
                off = a - FLASH_MIDDLE_LO;
                return TOP_SECTOR_EIGHT - off[SMALL_SECTOR_SHIFT+:3];
            end
            default: begin
                off = a - FLASH_SMALL_LO;
                return TOP_SECTOR_FOUR - {1'b0, off[SMALL_SECTOR_SHIFT+:2]};
            end
        endcase
    endfunction : sectorOf

    mmw_dec_state_t    state, next_state;
    mmw_region_t       next_region;
    logic [2:0]        next_sectorIdx;
    logic              curWrite, next_curWrite;
    logic              curRefused, next_curRefused;
    logic [ADDR_W-1:0] curAddr, next_curAddr;
    logic [DATA_W-1:0] curData, next_curData;
    logic              prevPf1Wr, next_prevPf1Wr;
    logic              protHold, next_protHold;
    logic              pendValid, next_pendValid;
    logic [1:0]        pendLag, next_pendLag;
    logic [ADDR_W-1:0] pendAddr, next_pendAddr;
    logic [DATA_W-1:0] pendData, next_pendData;
    logic              next_memStrobe, next_memWrite;
    logic [ADDR_W-1:0] next_memAddr;
    logic [DATA_W-1:0] next_memData;
    logic              readySync1, periphReady;
    logic              cntLoad, cntDone;
    logic [CNT_W-1:0]  cntValue;
    mmw_region_t       reqRegion;
    logic              reqRefused, reqProt, stallTake, readIssue;
    logic [CNT_W-1:0]  baseWait;

    mmw_wait_counter u_wait (
        .clk       (clk),
        .reset     (reset),
        .load      (cntLoad),
        .loadValue (cntValue),
        .done      (cntDone)
    );

    always_comb begin
        reqRegion  = decodeRegion(bus.addr, variant);
        reqRefused = (reqRegion == REG_NONE)
                   || (bus.prog && reqRegion inside {REG_PF0, REG_PF1, REG_PF2, REG_PF3})
                   || (bus.dma && bus.write && reqRegion == REG_PF0)
                   || (bus.dma && reqRegion inside {REG_PF1, REG_PF2})
                   || (bus.dma && reqRegion inside {REG_RAM_A, REG_RAM_B});
        reqProt    = protectEnable && reqRegion inside {REG_PF1, REG_PF2, REG_PF3};
        // Pending write blocks further writes, and protected reads until it drains
        stallTake  = pendValid && !reqRefused && (bus.write || reqProt);
        baseWait   = WAIT_ZERO;
        if (!bus.write) begin
            unique case (reqRegion)
                REG_PF0: baseWait = bus.dma ? PF0_DMA_RD_WAIT : PF0_CPU_RD_WAIT;
                REG_PF1, REG_PF2: baseWait = PFX_CPU_RD_WAIT;
                REG_PF3: baseWait = bus.dma ? PF3_DMA_RD_WAIT : PFX_CPU_RD_WAIT;
                default: baseWait = WAIT_ZERO;
            endcase
        end
    end

    always_comb begin
        next_state      = state;
        next_region     = region;
        next_sectorIdx  = sectorIdx;
        next_curWrite   = curWrite;
        next_curRefused = curRefused;
        next_curAddr    = curAddr;
        next_curData    = curData;
        next_prevPf1Wr  = prevPf1Wr;
        next_protHold   = protHold;
        next_pendValid  = pendValid;
        next_pendLag    = pendLag;
        next_pendAddr   = pendAddr;
        next_pendData   = pendData;
        next_memStrobe  = 1'b0;
        next_memWrite   = 1'b0;
        next_memAddr    = memAddr;
        next_memData    = memData;
        cntLoad         = 1'b0;
        cntValue        = WAIT_ZERO;
        readIssue       = 1'b0;
        bus.ack         = 1'b0;
        bus.refused     = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (bus.req && !stallTake) begin
                    next_state      = ST_WAIT;
                    next_region     = reqRegion;
                    next_sectorIdx  = (reqRegion == REG_FLASH) ? sectorOf(bus.addr, variant) : 3'h0;
                    next_curWrite   = bus.write;
                    next_curRefused = reqRefused;
                    next_curAddr    = bus.addr;
                    next_curData    = bus.wdata;
                    cntLoad         = 1'b1;
                    cntValue        = reqRefused ? WAIT_ZERO : baseWait
                                    + ((prevPf1Wr && bus.write && reqRegion == REG_PF1) ? PF1_B2B_STALL
                                       : WAIT_ZERO)
                                    + (protHold ? PROT_ALIGN_STALL : WAIT_ZERO);
                    readIssue       = !reqRefused && !bus.write;
                    next_prevPf1Wr  = 1'b0;
                    next_protHold   = 1'b0;
                end else begin
                    next_protHold  = protHold || (bus.req && stallTake && !bus.write);
                end
            end
            ST_WAIT: begin
                if (cntDone && (region != REG_PF1 || curRefused || periphReady)) begin
                    bus.ack        = 1'b1;
                    bus.refused    = curRefused;
                    next_state     = ST_IDLE;
                    next_prevPf1Wr = (region == REG_PF1) && curWrite && !curRefused;
                end
            end
        endcase
        if (readIssue) begin
            next_memStrobe = 1'b1;
            next_memAddr   = bus.addr;
            next_memData   = '0;
        end
        if (pendValid) begin
            if (pendLag != 2'h0) begin
                next_pendLag = pendLag - 2'h1;
            end else if (!readIssue) begin
                next_pendValid = 1'b0;
                next_memStrobe = 1'b1;
                next_memWrite  = 1'b1;
                next_memAddr   = pendAddr;
                next_memData   = pendData;
            end
        end
        // Writes are posted at the answer and reach the memory bus later
        if (bus.ack && curWrite && !curRefused) begin
            next_pendValid = 1'b1;
            next_pendLag   = WRITE_POST_LAG;
            next_pendAddr  = curAddr;
            next_pendData  = curData;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            readySync1  <= 1'b0;
            periphReady <= 1'b0;
        end else begin
            readySync1  <= periphReadyPin;
            periphReady <= readySync1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state      <= ST_IDLE;
            region     <= REG_NONE;
            sectorIdx  <= 3'h0;
            curWrite   <= 1'b0;
            curRefused <= 1'b0;
            curAddr    <= '0;
            curData    <= '0;
            prevPf1Wr  <= 1'b0;
            protHold   <= 1'b0;
            pendValid  <= 1'b0;
            pendLag    <= 2'h0;
            pendAddr   <= '0;
            pendData   <= '0;
            memStrobe  <= 1'b0;
            memWrite   <= 1'b0;
            memAddr    <= '0;
            memData    <= '0;
        end else begin
            state      <= next_state;
            region     <= next_region;
            sectorIdx  <= next_sectorIdx;
            curWrite   <= next_curWrite;
            curRefused <= next_curRefused;
            curAddr    <= next_curAddr;
            curData    <= next_curData;
            prevPf1Wr  <= next_prevPf1Wr;
            protHold   <= next_protHold;
            pendValid  <= next_pendValid;
            pendLag    <= next_pendLag;
            pendAddr   <= next_pendAddr;
            pendData   <= next_pendData;
            memStrobe  <= next_memStrobe;
            memWrite   <= next_memWrite;
            memAddr    <= next_memAddr;
            memData    <= next_memData;
        end
    end
endmodule : mmw_decoder

// *** mmw_pkg.sv ***
// Shared constants and types for the memory-map decoder and its bus master
package mmw_pkg;
    localparam int ADDR_W = 22;
    localparam int DATA_W = 16;
    localparam int CNT_W  = 3;

    // Low single-access RAM and peripheral frames
    localparam logic [21:0] RAM_A_LO = 22'h00_0000;
    localparam logic [21:0] RAM_A_HI = 22'h00_03FF;
    localparam logic [21:0] RAM_B_LO = 22'h00_0400;
    localparam logic [21:0] RAM_B_HI = 22'h00_07FF;
    localparam logic [21:0] PF0_LO   = 22'h00_0800;
    localparam logic [21:0] PF0_HI   = 22'h00_1FFF;
    localparam logic [21:0] PF3_LO   = 22'h00_4000;
    localparam logic [21:0] PF3_HI   = 22'h00_5FFF;
    localparam logic [21:0] PF1_LO   = 22'h00_6000;
    localparam logic [21:0] PF1_HI   = 22'h00_6FFF;
    localparam logic [21:0] PF2_LO   = 22'h00_7000;
    localparam logic [21:0] PF2_HI   = 22'h00_7FFF;

    // Flash sectors per density variant and the security words at the top
    localparam logic [21:0] FLASH_LARGE_LO  = 22'h30_0000;
    localparam logic [21:0] FLASH_MIDDLE_LO = 22'h32_0000;
    localparam logic [21:0] FLASH_SMALL_LO  = 22'h33_0000;
    localparam logic [21:0] FLASH_TOP       = 22'h33_FF7F;
    localparam logic [21:0] SEC_FILL_LO     = 22'h33_FF80;
    localparam logic [21:0] SEC_FILL_HI     = 22'h33_FFF5;
    localparam logic [21:0] SEC_CODE_HI     = 22'h33_FFEF;
    localparam logic [21:0] SEC_DATA_LO     = 22'h33_FFF0;
    localparam logic [21:0] BOOT_ENTRY_LO   = 22'h33_FFF6;
    localparam logic [21:0] BOOT_ENTRY_HI   = 22'h33_FFF7;
    localparam logic [21:0] PASSWORD_LO     = 22'h33_FFF8;
    localparam logic [21:0] PASSWORD_HI     = 22'h33_FFFF;
    localparam int LARGE_SECTOR_SHIFT = 15;
    localparam int SMALL_SECTOR_SHIFT = 14;
    localparam logic [2:0] TOP_SECTOR_EIGHT = 3'h7;
    localparam logic [2:0] TOP_SECTOR_FOUR  = 3'h3;
    localparam int PASSWORD_WORDS = 8;

    // Wait states and stalls
    localparam logic [CNT_W-1:0] WAIT_ZERO       = 3'h0;
    localparam logic [CNT_W-1:0] PF0_CPU_RD_WAIT = 3'h1;
    localparam logic [CNT_W-1:0] PF0_DMA_RD_WAIT = 3'h0;
    localparam logic [CNT_W-1:0] PFX_CPU_RD_WAIT = 3'h2;
    localparam logic [CNT_W-1:0] PF3_DMA_RD_WAIT = 3'h1;
    localparam logic [CNT_W-1:0] PF1_B2B_STALL   = 3'h1;
    localparam logic [CNT_W-1:0] PROT_ALIGN_STALL = 3'h1;
    localparam logic [1:0]       WRITE_POST_LAG  = 2'h2;

    typedef enum logic [1:0] {VAR_LARGE, VAR_MIDDLE, VAR_SMALL} mmw_variant_t;

    typedef enum logic [3:0] {
        REG_NONE, REG_RAM_A, REG_RAM_B, REG_PF0, REG_PF1, REG_PF2, REG_PF3,
        REG_FLASH, REG_SEC_FILL, REG_BOOT_ENTRY, REG_PASSWORD
    } mmw_region_t;
endpackage : mmw_pkg

// *** mmw_bus_if.sv ***
// Request/answer bus between the bus master and the decoder
`timescale 1ns/1ps
interface mmw_bus_if;
    import mmw_pkg::*;
    logic              req;
    logic              write;
    logic              dma;
    logic              prog;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              ack;
    logic              refused;

    modport device (input req, write, dma, prog, addr, wdata, output ack, refused);
    modport master (output req, write, dma, prog, addr, wdata, input ack, refused);
endinterface : mmw_bus_if

// *** mmw_wait_counter.sv ***
// Down-counter that times the wait states of one access
`timescale 1ns/1ps
module mmw_wait_counter
    import mmw_pkg::*;
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Control
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] loadValue,
    // Status
    output logic                  done
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;

    always_comb begin
        next_count = count;
        if (load) begin
            next_count = loadValue;
        end else if (count != WAIT_ZERO) begin
            next_count = count - 3'h1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count <= WAIT_ZERO;
        end else begin
            count <= next_count;
        end
    end

    assign done = (count == WAIT_ZERO);
endmodule : mmw_wait_counter

// *** mmw_master.sv ***
// Bus master end: issues accesses and polices the security word usage
`timescale 1ns/1ps
module mmw_master
    import mmw_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // Decoder bus
    mmw_bus_if.master              bus,
    // Command port
    input  wire logic              cmdValid,
    output logic                   cmdReady,
    input  wire logic              cmdWrite,
    input  wire logic              cmdDma,
    input  wire logic              cmdProgram,
    input  wire logic [ADDR_W-1:0] cmdAddr,
    input  wire logic [DATA_W-1:0] cmdData,
    input  wire logic              secureMode,
    // Completion
    output logic                   doneValid,
    output logic                   doneRefused,
    output logic                   doneBlocked
);
    typedef enum logic {ST_IDLE, ST_BUSY} mmw_mst_state_t;

    mmw_mst_state_t      state, next_state;
    logic                next_req, next_write, next_dma, next_program;
    logic [ADDR_W-1:0]   next_addr;
    logic [DATA_W-1:0]   next_wdata;
    logic                next_doneValid, next_doneRefused, next_doneBlocked;
    logic [PASSWORD_WORDS-1:0] pwZero, next_pwZero;
    logic [2:0]          pwIdx;
    logic                inPassword, inFill, blocked;
    logic [PASSWORD_WORDS-1:0] pwAfter;

    always_comb begin
        pwIdx      = cmdAddr[2:0];
        inPassword = cmdAddr >= PASSWORD_LO;
        inFill     = cmdAddr >= SEC_FILL_LO && cmdAddr <= SEC_FILL_HI;
        pwAfter    = pwZero;
        pwAfter[pwIdx] = (cmdData == '0);
        blocked    = (cmdWrite && inPassword && (&pwAfter))
                   || (secureMode && inFill && (cmdProgram || (cmdWrite && cmdData != '0)))
                   || (!secureMode && cmdProgram && !cmdWrite
                       && cmdAddr >= SEC_DATA_LO && cmdAddr <= SEC_FILL_HI);
    end

    always_comb begin
        next_state       = state;
        next_req         = bus.req;
        next_write       = bus.write;
        next_dma         = bus.dma;
        next_program     = bus.prog;
        next_addr        = bus.addr;
        next_wdata       = bus.wdata;
        next_pwZero      = pwZero;
        next_doneValid   = 1'b0;
        next_doneRefused = 1'b0;
        next_doneBlocked = 1'b0;
        cmdReady         = (state == ST_IDLE);
        unique case (state)
            ST_IDLE: begin
                if (cmdValid && blocked) begin
                    next_doneValid   = 1'b1;
                    next_doneBlocked = 1'b1;
                end else if (cmdValid) begin
                    next_state   = ST_BUSY;
                    next_req     = 1'b1;
                    next_write   = cmdWrite;
                    next_dma     = cmdDma;
                    next_program = cmdProgram;
                    next_addr    = cmdAddr;
                    next_wdata   = cmdData;
                end
            end
            ST_BUSY: begin
                if (bus.ack) begin
                    next_state       = ST_IDLE;
                    next_req         = 1'b0;
                    next_doneValid   = 1'b1;
                    next_doneRefused = bus.refused;
                    if (bus.write && !bus.refused && bus.addr >= PASSWORD_LO) begin
                        next_pwZero[bus.addr[2:0]] = (bus.wdata == '0);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state       <= ST_IDLE;
            bus.req     <= 1'b0;
            bus.write   <= 1'b0;
            bus.dma     <= 1'b0;
            bus.prog    <= 1'b0;
            bus.addr    <= '0;
            bus.wdata   <= '0;
            pwZero      <= '0;
            doneValid   <= 1'b0;
            doneRefused <= 1'b0;
            doneBlocked <= 1'b0;
        end else begin
            state       <= next_state;
            bus.req     <= next_req;
            bus.write   <= next_write;
            bus.dma     <= next_dma;
            bus.prog    <= next_program;
            bus.addr    <= next_addr;
            bus.wdata   <= next_wdata;
            pwZero      <= next_pwZero;
            doneValid   <= next_doneValid;
            doneRefused <= next_doneRefused;
            doneBlocked <= next_doneBlocked;
        end
    end
endmodule : mmw_master

// *** mmw_bus_assertions.sv ***
// Assertions on the bus between the master and the decoder
`timescale 1ns/1ps
module mmw_bus_assertions
    import mmw_pkg::*;
(
    // Clock and reset
    input wire logic              clk,
    input wire logic              reset,
    // Bus signals
    input wire logic              req,
    input wire logic              write,
    input wire logic              dma,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic              ack,
    input wire logic              refused
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    logic rd;
    assign rd = req && !write && !dma;

    function automatic logic inr(logic [ADDR_W-1:0] a, logic [ADDR_W-1:0] lo, logic [ADDR_W-1:0] hi);
        return a >= lo && a <= hi;
    endfunction : inr

    ack_one_cycle_a: assert property (ack |=> !ack) else $error("ack held");
    refused_with_ack_a: assert property (refused |-> ack) else $error("refused alone");
    ack_drops_req_a: assert property (ack |=> !req) else $error("req after ack");
    dma_frames_refused_a: assert property (ack && dma && inr(addr, PF1_LO, PF2_HI) |-> refused)
        else $error("dma served in frame 1 or 2");
    dma_pf0_write_a: assert property (ack && dma && write && inr(addr, PF0_LO, PF0_HI) |-> refused)
        else $error("dma write served in frame 0");
    unmapped_refused_a: assert property (ack && inr(addr, 22'h00_8000, 22'h2F_FFFF) |-> refused)
        else $error("unmapped access served");
    ram_read_wait_a: assert property ($rose(rd) && inr(addr, RAM_A_LO, RAM_B_HI) |-> !ack ##1 ack)
        else $error("low ram read waits");
    pf0_read_wait_a: assert property ($rose(rd) && inr(addr, PF0_LO, PF0_HI) |-> !ack [*2] ##1 ack)
        else $error("frame 0 read waits");
    pf2_read_wait_a: assert property ($rose(rd) && inr(addr, PF2_LO, PF2_HI) |-> !ack [*3] ##[0:8] ack)
        else $error("frame 2 read waits");
    pf3_dma_read_a: assert property ($rose(req) && dma && !write && inr(addr, PF3_LO, PF3_HI)
        |-> !ack [*2] ##[0:8] ack) else $error("frame 3 dma read waits");

    cover property (ack && refused);
    cover property (ack && write && !refused);
    cover property ($rose(rd) && inr(addr, PF1_LO, PF1_HI));
endmodule : mmw_bus_assertions

// *** memory_map_wait_state_decoder_test.sv ***
// Bench joining the bus master and the decoder
`timescale 1ns/1ps
module memory_map_wait_state_decoder_test
    import mmw_pkg::*;
;
    localparam logic NO  = 1'b0;
    localparam logic YES = 1'b1;
    logic              clk, reset, protectEnable, periphReadyPin, secureMode;
    mmw_variant_t      variant;
    mmw_region_t       region;
    logic [2:0]        sectorIdx;
    logic              memStrobe, memWrite, cmdValid, cmdReady, cmdWrite, cmdDma, cmdProgram;
    logic [ADDR_W-1:0] memAddr, cmdAddr, base, sz;
    logic [DATA_W-1:0] memData, cmdData;
    logic              doneValid, doneRefused, doneBlocked;
    logic              strobeLog[$];
    int                bad_count, checked, cycles, lat, l0, n;

    mmw_bus_if bus ();
    mmw_master u_mmw_master (.clk(clk), .reset(reset), .bus(bus.master), .cmdValid(cmdValid),
        .cmdReady(cmdReady), .cmdWrite(cmdWrite), .cmdDma(cmdDma), .cmdProgram(cmdProgram),
        .cmdAddr(cmdAddr), .cmdData(cmdData), .secureMode(secureMode), .doneValid(doneValid),
        .doneRefused(doneRefused), .doneBlocked(doneBlocked));
    mmw_decoder u_mmw_decoder (.clk(clk), .reset(reset), .bus(bus.device), .variant(variant),
        .protectEnable(protectEnable), .periphReadyPin(periphReadyPin), .region(region),
        .sectorIdx(sectorIdx), .memStrobe(memStrobe), .memWrite(memWrite), .memAddr(memAddr),
        .memData(memData));
    mmw_bus_assertions u_mmw_bus_assertions (.clk(clk), .reset(reset), .req(bus.req),
        .write(bus.write), .dma(bus.dma), .addr(bus.addr), .ack(bus.ack), .refused(bus.refused));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Memory bus strobes in order, 1 for a write
    always @(posedge clk) begin
        cycles++;
        if (memStrobe === 1'b1) strobeLog.push_back(memWrite);
        if (cycles == 8000) begin
            bad_count++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic access(input logic w, d, p, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] dat,
                          input logic expRef, expBlk);
        @(posedge clk);
        cmdValid   <= YES;
        cmdWrite   <= w;
        cmdDma     <= d;
        cmdProgram <= p;
        cmdAddr    <= a;
        cmdData    <= dat;
        @(posedge clk);
        cmdValid <= NO;
        lat = 0;
        do begin
            @(negedge clk);
            lat++;
        end while (doneValid !== 1'b1 && lat < 60);
        check(lat < 60, YES);
        check(doneRefused, expRef);
        check(doneBlocked, expBlk);
    endtask : access

    task automatic map(input logic w, d, p, input logic [ADDR_W-1:0] a, input logic expRef,
                       input mmw_region_t expReg, input logic [2:0] expSec);
        access(w, d, p, a, 16'h0000, expRef, NO);
        if (!expRef) begin
            check(region, expReg);
            check(sectorIdx, expSec);
        end
    endtask : map

    initial begin
        reset = YES;
        cmdValid = NO;
        cmdWrite = NO;
        cmdDma = NO;
        cmdProgram = NO;
        cmdAddr = '0;
        cmdData = '0;
        secureMode = NO;
        protectEnable = YES;
        periphReadyPin = YES;
        variant = VAR_LARGE;
        repeat (10) @(posedge clk);
        reset <= NO;
        for (int v = 0; v < 3; v++) begin
            base = v == 0 ? FLASH_LARGE_LO : v == 1 ? FLASH_MIDDLE_LO : FLASH_SMALL_LO;
            sz = v == 0 ? 22'h00_8000 : 22'h00_4000;
            n = v == 2 ? 4 : 8;
            @(posedge clk) variant <= mmw_variant_t'(v);
            for (int s = 0; s < n; s++) begin
                map(NO, NO, NO, base + sz * s, NO, REG_FLASH, 3'(n - 1 - s));
                map(NO, NO, NO, s == n - 1 ? FLASH_TOP : base + sz * (s + 1) - 1, NO, REG_FLASH, 3'(n - 1 - s));
            end
            map(NO, NO, NO, base - 1, YES, REG_NONE, 3'h0);
            map(NO, NO, NO, SEC_FILL_LO, NO, REG_SEC_FILL, 3'h0);
            map(NO, NO, NO, SEC_FILL_HI, NO, REG_SEC_FILL, 3'h0);
            map(NO, NO, NO, BOOT_ENTRY_HI, NO, REG_BOOT_ENTRY, 3'h0);
            map(NO, NO, NO, PASSWORD_HI, NO, REG_PASSWORD, 3'h0);
        end
        map(YES, NO, NO, RAM_B_HI, NO, REG_RAM_B, 3'h0);
        map(NO, YES, NO, PF0_HI, NO, REG_PF0, 3'h0);
        map(YES, YES, NO, PF0_LO, YES, REG_NONE, 3'h0);
        map(YES, NO, NO, PF0_LO, NO, REG_PF0, 3'h0);
        map(NO, YES, NO, PF1_LO, YES, REG_NONE, 3'h0);
        map(YES, NO, NO, PF1_HI, NO, REG_PF1, 3'h0);
        map(YES, YES, NO, PF2_LO, YES, REG_NONE, 3'h0);
        map(YES, YES, NO, PF3_HI, NO, REG_PF3, 3'h0);
        map(NO, NO, YES, PF3_LO, YES, REG_NONE, 3'h0);
        map(YES, NO, YES, PF1_LO, YES, REG_NONE, 3'h0);
        // Read latencies relative to a zero-wait low RAM read
        map(NO, NO, NO, RAM_A_HI, NO, REG_RAM_A, 3'h0);
        l0 = lat;
        map(NO, NO, NO, PF0_LO, NO, REG_PF0, 3'h0);
        check(lat - l0, 8'h01);
        map(NO, NO, NO, PF3_LO, NO, REG_PF3, 3'h0);
        check(lat - l0, 8'h02);
        map(NO, YES, NO, PF3_LO, NO, REG_PF3, 3'h0);
        check(lat - l0, 8'h01);
        map(NO, NO, NO, PF1_LO, NO, REG_PF1, 3'h0);
        check(lat - l0, 8'h02);
        @(posedge clk) periphReadyPin <= NO;
        map(NO, NO, NO, PF2_HI, NO, REG_PF2, 3'h0);
        check(lat - l0, 8'h02);
        fork
            begin
                repeat (20) @(posedge clk);
                periphReadyPin <= YES;
            end
        join_none
        map(NO, NO, NO, PF1_HI, NO, REG_PF1, 3'h0);
        check(lat - l0 >= 16, YES);
        for (int i = 0; i < PASSWORD_WORDS; i++) begin
            access(YES, NO, NO, PASSWORD_LO + i, 16'h0000, NO, i == PASSWORD_WORDS - 1);
        end
        @(posedge clk) secureMode <= YES;
        access(YES, NO, NO, SEC_FILL_LO, 16'h0001, NO, YES);
        access(YES, NO, NO, SEC_FILL_LO, 16'h0000, NO, NO);
        access(NO, NO, YES, SEC_FILL_HI, 16'h0000, NO, YES);
        @(posedge clk) secureMode <= NO;
        access(NO, NO, YES, SEC_CODE_HI, 16'h0000, NO, NO);
        access(NO, NO, YES, SEC_DATA_LO, 16'h0000, NO, YES);
        for (int p = 1; p >= 0; p--) begin
            @(posedge clk) protectEnable <= p[0];
            strobeLog.delete();
            access(YES, NO, NO, PF3_LO, 16'h1234, NO, NO);
            access(NO, NO, NO, PF3_HI, 16'h0000, NO, NO);
            repeat (8) @(posedge clk);
            check({strobeLog.size() == 2, strobeLog[0], strobeLog[1]}, 8'(5 + p));
        end
        access(YES, NO, NO, PF1_LO, 16'h0000, NO, NO);
        access(YES, NO, NO, PF1_HI, 16'h0000, NO, NO);
        check(lat - l0, 8'h02);
        final_report();
    end
endmodule : memory_map_wait_state_decoder_test
